// ===== dv/atc_props.sv
// Purpose: Port assertions for translation control
// Assumes: Register offsets as in the defines
// Notes: Bound to every top instance
`timescale 1ns/1ps
module atc_props (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic xlat_req_i,
  input wire logic xlat_busy_o,
  input wire logic xlat_done_o,
  input wire logic xlat_hit_o,
  input wire logic [31:0] xlat_entry_o,
  input wire logic tbl_req_o,
  input wire logic tbl_ack_i,
  input wire logic [31:0] tbl_data_i,
  input wire logic wbuf_flush_o,
  input wire logic cache_enable_o,
  input wire logic fast_rate_suppress_o,
  input wire logic aperture_32mb_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire wc = reg_write_i && reg_addr_i == 8'hb0;
  rst_clear_a: assert property (
    $rose(reset_n_i) |-> !cache_enable_o && !aperture_32mb_o)
    else $error("enable or size set after reset");
  en_write_a: assert property (
    wc |=> cache_enable_o == $past(reg_wdata_i[7]))
    else $error("cache enable not written");
  sup_write_a: assert property (
    wc |=> fast_rate_suppress_o == $past(reg_wdata_i[0]))
    else $error("suppress bit not written");
  flush_pulse_a: assert property (
    wbuf_flush_o == $past(wc)) else $error("write buffer flush wrong");
  size_gate_a: assert property (
    reg_read_i && reg_addr_i == 8'hb8 && !aperture_32mb_o
    |=> !reg_rdata_o[25]) else $error("base bit 25 not zero");
  stat_fast_a: assert property (
    reg_read_i && reg_addr_i == 8'hbc && fast_rate_suppress_o
    |=> !reg_rdata_o[2]) else $error("fast rate shown");
  dis_fetch_a: assert property (
    xlat_req_i && !xlat_busy_o && !xlat_done_o && !cache_enable_o
    |=> tbl_req_o && !xlat_done_o) else $error("disabled no fetch");
  hit_enabled_a: assert property (
    xlat_done_o && xlat_hit_o |-> $past(cache_enable_o))
    else $error("hit while disabled");
  tbl_hold_a: assert property (
    tbl_req_o && !tbl_ack_i |=> tbl_req_o) else $error("fetch dropped");
  ack_done_a: assert property (
    tbl_req_o && tbl_ack_i |=> xlat_done_o && !xlat_hit_o
    && xlat_entry_o == $past(tbl_data_i)) else $error("fetch result");
  cover property (xlat_done_o && xlat_hit_o);
  cover property (tbl_req_o && tbl_ack_i && !cache_enable_o);
  cover property (wbuf_flush_o && tbl_req_o);
endmodule // atc_props
bind atc_aperture_translation_control atc_props u_props (.*);

// ===== dv/atc_tb.sv
// Purpose: Self-checking bench with cache reference model
// Assumes: Four entry true LRU, fill only while enabled
// Notes: Seed 63
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i, reset_n_i, reg_write_i, reg_read_i, xlat_req_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, xlat_addr_i, xlat_entry_o;
  logic [31:0] tbl_addr_o, tbl_data_i;
  logic xlat_busy_o, xlat_done_o, xlat_hit_o, tbl_req_o, tbl_ack_i;
  logic wbuf_flush_o, cache_enable_o, fast_rate_suppress_o;
  logic aperture_32mb_o;
  logic [1:0] dly;
  logic en;
  int n_errors, n_checks, cyc;
  logic [19:0] q[$];
  atc_aperture_translation_control u_dut (.*);
  atc_tbl_model u_mem (.ref_clk_i, .reset_n_i, .tbl_req_i(tbl_req_o),
    .tbl_addr_i(tbl_addr_o), .delay_i(dly), .tbl_ack_o(tbl_ack_i),
    .tbl_data_o(tbl_data_i));
  task test_done;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write_i <= 1'b0;
    if (a == 8'hb0) en = d[7];
    if (!en) q.delete();
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_read_i <= 1'b0;
    #1 chk("rdata", e, reg_rdata_o);
  endtask
  task xl(logic [19:0] p, logic [1:0] d);
    int k;
    logic h;
    h = en && (p inside {q});
    @(posedge ref_clk_i);
    xlat_req_i <= 1'b1;
    xlat_addr_i <= {p, 12'h123};
    dly <= d;
    @(posedge ref_clk_i);
    k = 0;
    // Drop the request at the edge that completes it, else it reissues
    while (!h && !(tbl_req_o && tbl_ack_i) && k < 50) begin
      @(posedge ref_clk_i);
      k++;
    end
    xlat_req_i <= 1'b0;
    #1;
    while (!xlat_done_o && k < 60) begin
      @(posedge ref_clk_i) #1;
      k++;
    end
    if (!h) chk("tbl_addr", {p, 12'h0}, tbl_addr_o);
    chk("hit", h, xlat_hit_o);
    chk("entry", {p ^ 20'h3c3c3, 11'h0, ~p[0]}, xlat_entry_o);
    for (int i = 0; i < q.size(); i++) if (q[i] == p) q.delete(i);
    if (q.size() == 4) q.delete(0);
    if (en) q.push_back(p);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    {reset_n_i, reg_write_i, reg_read_i, xlat_req_i, en} = 5'h0;
    {reg_addr_i, reg_wdata_i, xlat_addr_i, dly} = 74'h0;
    void'($urandom(63));
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(8'hb0, 32'h0);
    rd(8'hb4, 32'h0);
    rd(8'hbc, 32'h7);
    rd(8'h10, 32'h0);
    wr(8'hb8, 32'hffffffff);
    rd(8'hb8, 32'hfc000000);
    wr(8'hb4, 32'hffffffff);
    rd(8'hb4, 32'h8);
    wr(8'hb8, 32'hffffffff);
    rd(8'hb8, 32'hfe000000);
    wr(8'hb0, 32'hffffffff);
    rd(8'hb0, 32'h81);
    rd(8'hbc, 32'h3);
    wr(8'hc0, 32'h4);
    rd(8'hc0, 32'h0);
    wr(8'hb0, 32'h80);
    wr(8'hc0, 32'h4);
    rd(8'hc0, 32'h4);
    // Six pages over four entries keeps eviction busy
    repeat (80) begin
      if ($urandom % 8 == 0) wr(8'hb0, {24'h0, 1'($urandom), 7'h0});
      xl(20'($urandom % 6), 2'($urandom));
    end
    wr(8'hb0, 32'h80);
    fork
      xl(20'h00777, 2'h3);
      begin
        @(posedge ref_clk_i);
        wr(8'hb0, 32'h0);
      end
    join
    wr(8'hb0, 32'h80);
    xl(20'h00777, 2'h0);
    test_done();
  end
endmodule // testbench

// ===== dv/atc_tbl_model.sv
// Purpose: Translation table in main memory
// Assumes: Answer delay of delay_i plus one cycles
// Notes: Data holds the entry from the cycle after the request through the answer cycle, toggles otherwise
`timescale 1ns/1ps
module atc_tbl_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic tbl_req_i,
  input wire logic [31:0] tbl_addr_i,
  input wire logic [1:0] delay_i,
  output logic tbl_ack_o,
  output logic [31:0] tbl_data_o
);
  logic [1:0] cnt;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbl_ack_o <= 1'b0;
      tbl_data_o <= 32'h0;
      cnt <= 2'h0;
    end else if (tbl_req_i && !tbl_ack_o) begin
      cnt <= (cnt == delay_i) ? 2'h0 : cnt + 2'h1;
      tbl_ack_o <= (cnt == delay_i);
      // Odd pages come back invalid, still to be cached
      tbl_data_o <= {tbl_addr_i[31:12] ^ 20'h3c3c3, 11'h0, ~tbl_addr_i[12]};
    end else begin
      // Stale data is inverted every cycle, so it is on the bus every other cycle
      tbl_ack_o <= 1'b0;
      tbl_data_o <= ~tbl_data_o;
    end
  end
endmodule // atc_tbl_model

// ===== rtl/atc_aperture_translation_control.v
// Purpose: Translation cache control, aperture size, rate suppress
// Assumes: Single 10 MHz clock, register port read data one cycle later
// Notes:   Cache holds page tags; table fetch handled by memory port
`timescale 1ns/1ps
`include "atc_defines.vh"
module atc_aperture_translation_control (
  input  wire                    ref_clk_i,
  input  wire                    reset_n_i,
  // Register port
  input  wire [`ATC_ADDR_W-1:0]  reg_addr_i,
  input  wire [31:0]             reg_wdata_i,
  input  wire                    reg_write_i,
  input  wire                    reg_read_i,
  output reg  [31:0]             reg_rdata_o,
  // Aperture translation request
  input  wire                    xlat_req_i,
  input  wire [31:0]             xlat_addr_i,
  output wire                    xlat_busy_o,
  output reg                     xlat_done_o,
  output reg                     xlat_hit_o,
  output reg  [31:0]             xlat_entry_o,
  // Translation table fetch from main memory
  output reg                     tbl_req_o,
  output reg  [31:0]             tbl_addr_o,
  input  wire                    tbl_ack_i,
  input  wire [31:0]             tbl_data_i,
  // Side effects
  output reg                     wbuf_flush_o,
  output wire                    cache_enable_o,
  output wire                    fast_rate_suppress_o,
  output wire                    aperture_32mb_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg                      translation_cache_enable;
  reg                      fast_rate_suppress;
  reg                      aperture_size_select;
  reg  [31:0]              aperture_base;
  reg  [2:0]               rate_cmd;
  reg                      cache_en_seen;

  wire wr_ctrl = reg_write_i && (reg_addr_i == `ATC_OFS_CTRL);
  wire wr_size = reg_write_i && (reg_addr_i == `ATC_OFS_SIZE);
  wire wr_base = reg_write_i && (reg_addr_i == `ATC_OFS_BASE);
  wire wr_cmd  = reg_write_i && (reg_addr_i == `ATC_OFS_CMD);

  assign cache_enable_o       = translation_cache_enable;
  assign fast_rate_suppress_o = fast_rate_suppress;
  assign aperture_32mb_o      = aperture_size_select;

  // Bit 25 of the base is writable only in the 32 MB setting
  function [31:0] base_view;
    input [31:0] base;
    input        sel32;
    begin
      base_view = base & `ATC_BASE_MASK;
      if (!sel32)
        base_view[`ATC_BIT_BASE25] = 1'b0;
    end
  endfunction

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      translation_cache_enable <= 1'b0;
      fast_rate_suppress       <= 1'b0;
      aperture_size_select     <= 1'b0;
      aperture_base            <= 32'h00000000;
      rate_cmd                 <= `ATC_RATE_RST;
    end else begin
      if (wr_ctrl) begin
        // Only bits 7 and 0 are stored
        translation_cache_enable <= reg_wdata_i[`ATC_BIT_EN];
        fast_rate_suppress       <= reg_wdata_i[`ATC_BIT_SUPPRESS];
      end
      if (wr_size)
        aperture_size_select <= reg_wdata_i[`ATC_BIT_SIZE];
      if (wr_base)
        aperture_base <= base_view(reg_wdata_i, aperture_size_select);
      else if (!aperture_size_select)
        aperture_base[`ATC_BIT_BASE25] <= 1'b0;
      if (wr_cmd) begin
        rate_cmd[1:0] <= reg_wdata_i[1:0];
        if (!fast_rate_suppress)
          rate_cmd[`ATC_BIT_FAST] <= reg_wdata_i[`ATC_BIT_FAST];
      end
    end
  end

  // Write buffer flush on any write that sets or clears the enable
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wbuf_flush_o <= 1'b0;
    end else begin
      wbuf_flush_o <= wr_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr_i)
      `ATC_OFS_CTRL: begin
        next_rdata[`ATC_BIT_EN]       = translation_cache_enable;
        next_rdata[`ATC_BIT_SUPPRESS] = fast_rate_suppress;
      end
      `ATC_OFS_SIZE: next_rdata[`ATC_BIT_SIZE] = aperture_size_select;
      `ATC_OFS_BASE:
        next_rdata = base_view(aperture_base, aperture_size_select);
      `ATC_OFS_STAT: begin
        next_rdata[2:0] = `ATC_RATE_CAP;
        if (fast_rate_suppress)
          next_rdata[`ATC_BIT_FAST] = 1'b0;
      end
      `ATC_OFS_CMD: next_rdata[2:0] = rate_cmd;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_read_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= 32'h00000000;
  end

  // ---------------------------------------------------------------
  // Translation cache
  // ---------------------------------------------------------------
  reg                    valid [0:`ATC_ENTRIES-1];
  reg [`ATC_TAG_W-1:0]   tag   [0:`ATC_ENTRIES-1];
  reg [31:0]             entry [0:`ATC_ENTRIES-1];
  wire [`ATC_IDX_W-1:0]  victim;
  reg                    lru_touch;
  reg [`ATC_IDX_W-1:0]   lru_idx;

  wire [`ATC_TAG_W-1:0] req_tag = xlat_addr_i[31:`ATC_PAGE_LSB];

  // Hit search, suppressed entirely while disabled
  reg                    hit;
  reg [`ATC_IDX_W-1:0]   hit_idx;
  integer i;
  integer s;
  always @* begin
    hit     = 1'b0;
    hit_idx = {`ATC_IDX_W{1'b0}};
    for (s = 0; s < `ATC_ENTRIES; s = s + 1)
      if (valid[s] && tag[s] == req_tag && translation_cache_enable) begin
        hit     = 1'b1;
        hit_idx = s[`ATC_IDX_W-1:0];
      end
  end

  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;
  reg                  state;
  reg [`ATC_TAG_W-1:0] fetch_tag;

  assign xlat_busy_o = (state == ST_FETCH);

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state         <= ST_IDLE;
      fetch_tag     <= {`ATC_TAG_W{1'b0}};
      cache_en_seen <= 1'b0;
      tbl_req_o     <= 1'b0;
      tbl_addr_o    <= 32'h00000000;
      xlat_done_o   <= 1'b0;
      xlat_hit_o    <= 1'b0;
      xlat_entry_o  <= 32'h00000000;
      lru_touch     <= 1'b0;
      lru_idx       <= {`ATC_IDX_W{1'b0}};
      for (i = 0; i < `ATC_ENTRIES; i = i + 1) begin
        valid[i] <= 1'b0;
        tag[i]   <= {`ATC_TAG_W{1'b0}};
        entry[i] <= 32'h00000000;
      end
    end else begin
      xlat_done_o <= 1'b0;
      lru_touch   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (xlat_req_i && hit) begin
            xlat_done_o  <= 1'b1;
            xlat_hit_o   <= 1'b1;
            xlat_entry_o <= entry[hit_idx];
            lru_touch    <= 1'b1;
            lru_idx      <= hit_idx;
          end else if (xlat_req_i) begin
            // Enable sampled at issue keeps the fill decision stable
            state         <= ST_FETCH;
            fetch_tag     <= req_tag;
            cache_en_seen <= translation_cache_enable;
            tbl_req_o     <= 1'b1;
            tbl_addr_o    <= {req_tag, `ATC_PAGE_LSB'h0};
          end
        end
        ST_FETCH: begin
          if (tbl_ack_i) begin
            tbl_req_o    <= 1'b0;
            state        <= ST_IDLE;
            xlat_done_o  <= 1'b1;
            xlat_hit_o   <= 1'b0;
            xlat_entry_o <= tbl_data_i;
            // Fill even invalid entries, only when still enabled
            if (cache_en_seen && translation_cache_enable) begin
              valid[victim] <= 1'b1;
              tag[victim]   <= fetch_tag;
              entry[victim] <= tbl_data_i;
              lru_touch     <= 1'b1;
              lru_idx       <= victim;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (!translation_cache_enable)
        for (i = 0; i < `ATC_ENTRIES; i = i + 1)
          valid[i] <= 1'b0;
    end
  end

  atc_lru u_lru (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .touch_i     (lru_touch),
    .touch_idx_i (lru_idx),
    .victim_o    (victim)
  );
endmodule // atc_aperture_translation_control

// ===== rtl/atc_defines.vh
// What this block does
// - Enable bit set: cache serves aperture lookups
// - Enable resets 0; while 0 flush valids
// - Disabled: translations bypass cache, never hit
// - Disabled: aperture request fetches table entry first
// - Disabled: fetched entries not written to cache
// - Invalid fetched entry still cached, LRU evicted
// - Enable set or clear flushes write buffer
// - Enable change never corrupts access in flight
// - Suppress bit set: fastest rate reads 0
// - Size bit 0: base bit 25 reads 0
// - Size bit 1: base bit 25 read/write
// - Size register resets 0, 64 MB aperture
// - Suppress set: command fastest-rate writes ignored
//
// Purpose: Constants for the aperture translation control block
// Assumes: 8-bit byte register offsets, 32-bit register data
// Notes:   Definitions only
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH

`define ATC_ADDR_W        8
`define ATC_OFS_CTRL      8'hb0
`define ATC_OFS_SIZE      8'hb4
`define ATC_OFS_BASE      8'hb8
`define ATC_OFS_STAT      8'hbc
`define ATC_OFS_CMD       8'hc0
`define ATC_BIT_SUPPRESS  0
`define ATC_BIT_EN        7
`define ATC_BIT_SIZE      3
`define ATC_BIT_BASE25    25
`define ATC_BIT_FAST      2
`define ATC_CTRL_RST      32'h00000000
`define ATC_SIZE_RST      8'h00
`define ATC_BASE_MASK     32'hfe000000
`define ATC_RATE_CAP      3'h7
`define ATC_RATE_RST      3'h0
`define ATC_ENTRIES       4
`define ATC_IDX_W         2
`define ATC_TAG_W         20
`define ATC_PAGE_LSB      12

`endif

// ===== rtl/atc_lru.v
// Purpose: Least recently used tracker for the translation cache
// Assumes: Four entries, age counters, one touch per cycle
// Notes:   Victim is the entry with the highest age
`timescale 1ns/1ps
`include "atc_defines.vh"
module atc_lru (
  input  wire                    ref_clk_i,
  input  wire                    reset_n_i,
  input  wire                    touch_i,
  input  wire [`ATC_IDX_W-1:0]   touch_idx_i,
  output reg  [`ATC_IDX_W-1:0]   victim_o
);
  reg [`ATC_IDX_W-1:0] age [0:`ATC_ENTRIES-1];
  integer k;
  integer j;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (k = 0; k < `ATC_ENTRIES; k = k + 1)
        age[k] <= k[`ATC_IDX_W-1:0];
    end else if (touch_i) begin
      for (k = 0; k < `ATC_ENTRIES; k = k + 1) begin
        if (k[`ATC_IDX_W-1:0] == touch_idx_i)
          age[k] <= {`ATC_IDX_W{1'b0}};
        else if (age[k] < age[touch_idx_i])
          age[k] <= age[k] + 1'b1;
      end
    end
  end

  always @* begin
    victim_o = {`ATC_IDX_W{1'b0}};
    // Own loop index so the comb search never shares a driver with the
    // clocked age update
    for (j = 0; j < `ATC_ENTRIES; j = j + 1)
      if (age[j] == {`ATC_IDX_W{1'b1}})
        victim_o = j[`ATC_IDX_W-1:0];
  end
endmodule // atc_lru
